//--- logic/mdh_device.sv
// driver end: lin pins, zero-crossing, fault output, enables, sequencer, status link
`timescale 1ns/1ps
module mdh_device
	import mdh_pkg::*;
#(
	parameter bit HAS_LIN = 1'b1,
	parameter int STANDBY_CYC_P = STANDBY_CYC,
	parameter int BUCK_SETTLE_P = BUCK_SETTLE_CYC,
	parameter int LINK_BIT_P = LINK_BIT_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// pins toward the host
	mdh_if.dev bus,
	// lin bus wire toward other nodes
	input wire logic lin_bus_in,
	output logic lin_bus_oe,
	// comparator results, one per winding, against each neutral
	input wire logic [2:0] phase_gt_sim,
	input wire logic [2:0] phase_gt_ext,
	// analog conditions
	input wire logic amp1_above_dac,
	input wire logic lin_fault_cond,
	input wire logic dev_fault_cond,
	input wire logic buck_fb_present,
	// power and driver enables
	output logic gate_enable,
	output logic amp_enable,
	output logic buck_enable,
	output logic ldo5_enable,
	output logic standby,
	// fault state
	output logic hw_fault,
	output logic buck_uvlo_fault
);
	localparam int SW = 17;
	localparam int SBW = $clog2(STANDBY_CYC_P + 1);
	localparam int BKW = $clog2(BUCK_SETTLE_P + 1);

	if (STANDBY_CYC_P < 1 || BUCK_SETTLE_P < 1) begin : g_chk_cnt
		$error("mdh_device: counts must be at least one cycle");
	end
	if (GATE_OFF_LAT > GATE_OFF_CYC) begin : g_chk_gate
		$error("mdh_device: gate shutdown latency too long for the clock");
	end

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	wire [SW-1:0] raw_in = {phase_gt_ext, phase_gt_sim, buck_fb_present, dev_fault_cond,
		lin_fault_cond, amp1_above_dac, lin_bus_in, bus.status_link_pin, bus.chip_enable,
		bus.phase_select_hi, bus.phase_select_lo, bus.lin_fault_tx_arm, bus.lin_tx};
	wire [2:0] ext_s;
	wire [2:0] sim_s;
	wire fb_s;
	wire dfault_s;
	wire lfault_s;
	wire amp_s;
	wire lbus_s;
	wire link_s;
	wire ce_s;
	wire sel_hi_s;
	wire sel_lo_s;
	wire arm_s;
	wire tx_s;
	assign {ext_s, sim_s, fb_s, dfault_s, lfault_s, amp_s, lbus_s, link_s, ce_s,
		sel_hi_s, sel_lo_s, arm_s, tx_s} = sync2_r;

	// all pins and analog flags are asynchronous; the first stage feeds only the second
	always_ff @(posedge clock) begin
		sync1_r <= raw_in;
		sync2_r <= sync1_r;
	end

	// ------------------------------------------------------------
	// chip enable edge, standby timer
	// ------------------------------------------------------------
	logic ce_d_r;
	logic [SBW-1:0] sb_cnt_r;
	wire ce_rise = ce_s & ~ce_d_r;
	wire sb_done = (sb_cnt_r == SBW'(STANDBY_CYC_P));

	// the delay lets software toggle enable to clear faults without dropping to standby
	always_ff @(posedge clock) begin
		ce_d_r <= rst ? 1'b0 : ce_s;
		if (rst || ce_s) begin
			sb_cnt_r <= '0;
		end else if (!sb_done) begin
			sb_cnt_r <= sb_cnt_r + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// power-up sequencer
	// ------------------------------------------------------------
	mdh_seq_st_t seq_r;
	mdh_seq_st_t seq_nxt;
	logic [BKW-1:0] bk_cnt_r;
	wire bk_done = (bk_cnt_r == BKW'(BUCK_SETTLE_P));

	// a failed buck is retried only by an enable rising edge
	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			SEQ_OFF: seq_nxt = SEQ_BUCK;
			SEQ_BUCK: if (bk_done) seq_nxt = fb_s ? SEQ_RUN : SEQ_FAULT;
			SEQ_RUN: if (!fb_s) seq_nxt = SEQ_FAULT;
			SEQ_FAULT: if (ce_rise) seq_nxt = SEQ_BUCK;
			default: seq_nxt = SEQ_OFF;
		endcase
	end

	// settle counter runs only while the buck is starting
	always_ff @(posedge clock) begin
		seq_r <= rst ? SEQ_OFF : seq_nxt;
		if (rst || seq_r != SEQ_BUCK) begin
			bk_cnt_r <= '0;
		end else if (!bk_done) begin
			bk_cnt_r <= bk_cnt_r + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// fault latch, lin arm latch
	// ------------------------------------------------------------
	logic hw_fault_r;
	logic armed_r;
	wire hw_fault_nxt = dfault_s | (hw_fault_r & ~ce_rise); // a new fault beats the clear
	wire armed_nxt = HAS_LIN & ~lfault_s & (armed_r | arm_s);
	wire any_fault = hw_fault_r | (seq_r == SEQ_FAULT);

	always_ff @(posedge clock) begin
		hw_fault_r <= rst ? 1'b0 : hw_fault_nxt;
		armed_r <= rst ? 1'b0 : armed_nxt;
	end

	// ------------------------------------------------------------
	// zero-crossing selection
	// ------------------------------------------------------------
	logic [7:0] cfg_r;
	wire [2:0] cmp_sel = cfg_r[CFG_EXT_NEUTRAL] ? ext_s : sim_s;
	wire [1:0] ph_code = {sel_hi_s, sel_lo_s};
	wire ph_valid = (ph_code != PH_NONE);
	wire [1:0] ph_idx = ph_code - 2'h1;
	wire zc_level = cmp_sel[ph_idx];

	// ------------------------------------------------------------
	// pin and enable output flops
	// ------------------------------------------------------------
	logic lin_bus_oe_r;
	logic rx_oe_r;
	logic arm_o_r;
	logic arm_oe_r;
	logic zc_oe_r;
	logic ocf_oe_r;
	logic gate_en_r;
	logic amp_en_r;
	logic buck_en_r;
	logic ldo5_en_r;
	logic standby_r;
	logic buck_fault_r;

	// code 00 keeps the last comparator state so the output does not jump between windings
	always_ff @(posedge clock) begin
		if (rst) begin
			lin_bus_oe_r <= 1'b0;
			rx_oe_r <= 1'b0;
			arm_o_r <= 1'b0;
			arm_oe_r <= 1'b0;
			zc_oe_r <= 1'b0;
			ocf_oe_r <= 1'b0;
		end else begin
			lin_bus_oe_r <= armed_r & ~tx_s;
			rx_oe_r <= HAS_LIN & ~lbus_s;
			arm_o_r <= armed_nxt;
			arm_oe_r <= HAS_LIN;
			zc_oe_r <= ph_valid ? ~zc_level : zc_oe_r;
			ocf_oe_r <= (amp_s & amp_en_r) | any_fault | dfault_s;
		end
	end

	// enables and fault indications toward the power stage
	always_ff @(posedge clock) begin
		if (rst) begin
			gate_en_r <= 1'b0;
			amp_en_r <= 1'b0;
			buck_en_r <= 1'b0;
			ldo5_en_r <= 1'b0;
			standby_r <= 1'b0;
			buck_fault_r <= 1'b0;
		end else begin
			gate_en_r <= ce_s & ~hw_fault_nxt & (seq_nxt != SEQ_FAULT);
			amp_en_r <= ce_s;
			buck_en_r <= (seq_nxt == SEQ_BUCK) || (seq_nxt == SEQ_RUN);
			ldo5_en_r <= (seq_nxt == SEQ_RUN) & (HAS_LIN | ce_s);
			standby_r <= sb_done & ~ce_s;
			buck_fault_r <= (seq_nxt == SEQ_FAULT);
		end
	end

	// ------------------------------------------------------------
	// status link
	// ------------------------------------------------------------
	logic [7:0] sent_r;
	logic tx_ready;
	logic rx_valid;
	logic [7:0] rx_data;
	logic rx_err;
	logic [7:0] status;
	always_comb begin
		status = STATUS_RESET;
		status[ST_HW_FAULT] = hw_fault_r;
		status[ST_BUCK_FAULT] = buck_fault_r;
		status[ST_LIN_FAULT] = lfault_s;
		status[ST_OVERCUR] = amp_s & amp_en_r;
		status[ST_ARMED] = armed_r;
		status[ST_STANDBY] = standby_r;
		status[ST_EXT_NEUTRAL] = cfg_r[CFG_EXT_NEUTRAL];
		status[ST_LDO5_ON] = ldo5_en_r;
	end
	wire send = tx_ready & (status != sent_r);

	// a changed status byte goes out once the line is free; a good byte in sets the config
	always_ff @(posedge clock) begin
		if (rst) begin
			sent_r <= STATUS_RESET;
			cfg_r <= CFG_RESET;
		end else begin
			sent_r <= send ? status : sent_r;
			cfg_r <= (rx_valid & ~rx_err) ? rx_data : cfg_r;
		end
	end

	mdh_uart #(.BIT_CYC(LINK_BIT_P)) u_link (
		.clock(clock),
		.rst(rst),
		.line_in(link_s),
		.pull_low(bus.link_dev_oe),
		.tx_valid(send),
		.tx_data(status),
		.tx_ready(tx_ready),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.rx_err(rx_err)
	);

	// ------------------------------------------------------------
	// output wiring
	// ------------------------------------------------------------
	assign bus.lin_rx_oe = rx_oe_r;
	assign bus.arm_dev_o = arm_o_r;
	assign bus.arm_dev_oe = arm_oe_r;
	assign bus.zc_oe = zc_oe_r;
	assign bus.ocf_oe = ocf_oe_r;
	assign lin_bus_oe = lin_bus_oe_r;
	assign gate_enable = gate_en_r;
	assign amp_enable = amp_en_r;
	assign buck_enable = buck_en_r;
	assign ldo5_enable = ldo5_en_r;
	assign standby = standby_r;
	assign hw_fault = hw_fault_r;
	assign buck_uvlo_fault = buck_fault_r;
endmodule : mdh_device

//--- logic/mdh_host.sv
// host end: drives control pins, arms the lin transmitter, talks on the status link
`timescale 1ns/1ps
module mdh_host
	import mdh_pkg::*;
#(
	parameter int ARM_CYC = ARM_PULSE_CYC,
	parameter int LINK_BIT_P = LINK_BIT_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// pins toward the driver
	mdh_if.host bus,
	// lin data
	input wire logic lin_tx_data,
	output logic lin_rx_data,
	input wire logic arm_req,
	output logic lin_fault_n,
	// commutation
	input wire logic commute,
	input wire logic [1:0] phase_code,
	input wire logic ce_in,
	output logic zero_cross,
	output logic ovc_fault_n,
	// status link
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic stat_valid,
	output logic [7:0] stat_data,
	output logic stat_err
);
	localparam int AW = $clog2(ARM_CYC + 1);
	if (ARM_CYC < 1) begin : g_chk
		$error("mdh_host: ARM_CYC must be at least 1");
	end

	// pins from the driver pass two flops
	logic [4:0] s1_r;
	logic [4:0] s2_r;
	always_ff @(posedge clock) begin
		s1_r <= {bus.status_link_pin, bus.overcurrent_fault_out, bus.zero_cross_out,
			bus.lin_fault_tx_arm, bus.lin_rx};
		s2_r <= s1_r;
	end

	logic [AW-1:0] arm_cnt_r;
	logic [2:0] oe_hist_r;
	logic arm_oe_r;
	logic tx_r;
	logic rx_r;
	logic fault_n_r;
	logic [1:0] sel_r;
	logic ce_r;
	logic zc_r;
	logic ovc_r;
	wire arm_go = arm_req & (arm_cnt_r == '0);
	wire monitor = ~arm_oe_r & (oe_hist_r == 3'h0); // own drive has left the sync chain

	// the arm pin is an output only for the pulse, then it turns back into a fault monitor
	always_ff @(posedge clock) begin
		if (rst) begin
			arm_cnt_r <= '0;
			oe_hist_r <= '0;
			arm_oe_r <= 1'b0;
			fault_n_r <= 1'b0;
		end else begin
			arm_cnt_r <= arm_go ? AW'(ARM_CYC) : arm_cnt_r - AW'(arm_cnt_r != '0);
			arm_oe_r <= (arm_cnt_r != '0);
			oe_hist_r <= {oe_hist_r[1:0], arm_oe_r};
			fault_n_r <= monitor ? s2_r[1] : fault_n_r;
		end
	end

	// phase code changes only with a commutation strobe
	always_ff @(posedge clock) begin
		if (rst) begin
			tx_r <= 1'b1;
			sel_r <= PH_NONE;
			ce_r <= 1'b0;
		end else begin
			tx_r <= lin_tx_data;
			sel_r <= commute ? phase_code : sel_r;
			ce_r <= ce_in;
		end
		rx_r <= rst ? 1'b1 : s2_r[0];
		zc_r <= rst ? 1'b1 : s2_r[2];
		ovc_r <= rst ? 1'b1 : s2_r[3];
	end

	mdh_uart #(.BIT_CYC(LINK_BIT_P)) u_link (
		.clock(clock),
		.rst(rst),
		.line_in(s2_r[4]),
		.pull_low(bus.link_host_oe),
		.tx_valid(cmd_valid),
		.tx_data(cmd_data),
		.tx_ready(cmd_ready),
		.rx_valid(stat_valid),
		.rx_data(stat_data),
		.rx_err(stat_err)
	);

	assign bus.lin_tx = tx_r;
	assign bus.arm_host_o = arm_oe_r;
	assign bus.arm_host_oe = arm_oe_r;
	assign bus.phase_select_lo = sel_r[0];
	assign bus.phase_select_hi = sel_r[1];
	assign bus.chip_enable = ce_r;
	assign lin_rx_data = rx_r;
	assign lin_fault_n = fault_n_r;
	assign zero_cross = zc_r;
	assign ovc_fault_n = ovc_r;
endmodule : mdh_host

//--- logic/mdh_if.sv
// pin-level carrier between the driver end and the host end
`timescale 1ns/1ps
interface mdh_if;
	// lin transmit and receive
	logic lin_tx;
	logic lin_rx_oe;
	logic lin_rx;
	// shared fault report / transmit arm pin
	logic arm_host_o;
	logic arm_host_oe;
	logic arm_dev_o;
	logic arm_dev_oe;
	logic lin_fault_tx_arm;
	// zero-crossing selection and output
	logic phase_select_lo;
	logic phase_select_hi;
	logic zc_oe;
	logic zero_cross_out;
	// chip enable and overcurrent/fault
	logic chip_enable;
	logic ocf_oe;
	logic overcurrent_fault_out;
	// status link, open drain from both sides
	logic link_dev_oe;
	logic link_host_oe;
	logic status_link_pin;

	// open-drain lines read high unless someone pulls; the host overrides the weak device drive
	assign lin_rx = ~lin_rx_oe;
	assign zero_cross_out = ~zc_oe;
	assign overcurrent_fault_out = ~ocf_oe;
	assign status_link_pin = ~(link_dev_oe | link_host_oe);
	assign lin_fault_tx_arm = arm_host_oe ? arm_host_o : (arm_dev_oe & arm_dev_o);

	modport dev (
		input lin_tx, lin_fault_tx_arm, phase_select_lo, phase_select_hi,
		input chip_enable, status_link_pin,
		output lin_rx_oe, arm_dev_o, arm_dev_oe, zc_oe, ocf_oe, link_dev_oe
	);
	modport host (
		input lin_rx, lin_fault_tx_arm, zero_cross_out, overcurrent_fault_out, status_link_pin,
		output lin_tx, arm_host_o, arm_host_oe, phase_select_lo, phase_select_hi,
		output chip_enable, link_host_oe
	);
endinterface : mdh_if

//--- logic/mdh_pkg.sv
// shared constants and types for both ends of the motor driver host signals
package mdh_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int CLK_MHZ = 125;
	localparam int GATE_OFF_NS = 100;
	localparam int GATE_OFF_CYC = (GATE_OFF_NS * CLK_MHZ) / 1000; // longest, rounded down
	localparam int GATE_OFF_LAT = 3; // two sync stages plus the output flop
	localparam int STANDBY_MS = 1;
	localparam int STANDBY_CYC = STANDBY_MS * (CLK_HZ / 1000);
	localparam int BUCK_SETTLE_US = 100;
	localparam int BUCK_SETTLE_CYC = BUCK_SETTLE_US * CLK_MHZ;
	localparam int ARM_PULSE_CYC = 8;
	// ------------------------------------------------------------
	// status link framing
	// ------------------------------------------------------------
	localparam int LINK_BAUD = 9600;
	localparam int LINK_BIT_CYC = CLK_HZ / LINK_BAUD;
	localparam int LINK_FRAME_BITS = 10; // start, eight data, stop
	// ------------------------------------------------------------
	// phase select codes {hi, lo}
	// ------------------------------------------------------------
	localparam logic [1:0] PH_NONE = 2'h0;
	localparam logic [1:0] PH_A = 2'h1;
	localparam logic [1:0] PH_B = 2'h2;
	localparam logic [1:0] PH_C = 2'h3;
	// ------------------------------------------------------------
	// status byte bits, config byte bits
	// ------------------------------------------------------------
	localparam int ST_HW_FAULT = 7;
	localparam int ST_BUCK_FAULT = 6;
	localparam int ST_LIN_FAULT = 5;
	localparam int ST_OVERCUR = 4;
	localparam int ST_ARMED = 3;
	localparam int ST_STANDBY = 2;
	localparam int ST_EXT_NEUTRAL = 1;
	localparam int ST_LDO5_ON = 0;
	localparam int CFG_EXT_NEUTRAL = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {UART_IDLE = 2'b00, UART_TX = 2'b01, UART_RX = 2'b10} mdh_uart_st_t;
	typedef enum logic [1:0] {SEQ_OFF = 2'b00, SEQ_BUCK = 2'b01, SEQ_RUN = 2'b11,
		SEQ_FAULT = 2'b10} mdh_seq_st_t;
endpackage : mdh_pkg

//--- logic/mdh_uart.sv
// half-duplex open-drain character engine for the status link
`timescale 1ns/1ps
module mdh_uart
	import mdh_pkg::*;
#(
	parameter int BIT_CYC = LINK_BIT_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// line level, already synchronised; pull request
	input wire logic line_in,
	output logic pull_low,
	// transmit side
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	// receive side
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_err
);
	localparam int CW = $clog2(BIT_CYC + 1);
	localparam logic [CW-1:0] BIT_END = CW'(BIT_CYC - 1);
	localparam logic [CW-1:0] MID_START = CW'(BIT_CYC - BIT_CYC / 2);
	localparam logic [3:0] LAST_BIT = 4'(LINK_FRAME_BITS - 1);

	if (BIT_CYC < 4) begin : g_chk
		$error("mdh_uart: BIT_CYC must be at least 4");
	end

	mdh_uart_st_t st_r;
	logic [CW-1:0] cnt_r;
	logic [3:0] idx_r;
	logic [9:0] sh_r;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire cnt_end = (cnt_r == BIT_END);
	// a level, not an edge: a start bit that began while we were still sending is caught
	wire start_seen = ~line_in;
	wire last = (idx_r == LAST_BIT);

	// one bit counter serves both directions, which half duplex allows;
	// our own transmission is never looked at as a received character
	always_ff @(posedge clock) begin
		rx_valid <= 1'b0;
		cnt_r <= cnt_end ? '0 : cnt_r + 1'b1;
		if (rst) begin
			st_r <= UART_IDLE;
			idx_r <= '0;
			sh_r <= '1;
			pull_low <= 1'b0;
			tx_ready <= 1'b1;
			rx_data <= '0;
			rx_err <= 1'b0;
		end else begin
			case (st_r)
				UART_IDLE: begin
					cnt_r <= '0;
					idx_r <= '0;
					if (tx_valid) begin
						st_r <= UART_TX;
						sh_r <= {1'b1, tx_data, 1'b0};
						pull_low <= 1'b1;
						tx_ready <= 1'b0;
					end else if (start_seen) begin
						st_r <= UART_RX;
						cnt_r <= MID_START;
						tx_ready <= 1'b0;
					end
				end
				UART_TX: if (cnt_end) begin
					idx_r <= idx_r + 1'b1;
					sh_r <= {1'b1, sh_r[9:1]};
					pull_low <= ~sh_r[1] & ~last;
					if (last) begin
						st_r <= UART_IDLE;
						tx_ready <= 1'b1;
					end
				end
				UART_RX: if (cnt_end) begin
					idx_r <= idx_r + 1'b1;
					sh_r <= {line_in, sh_r[9:1]};
					if ((idx_r == 4'h0 && line_in) || last) begin
						st_r <= UART_IDLE; // a start bit that reads high was a glitch
						tx_ready <= 1'b1;
					end
					if (last) begin
						rx_valid <= 1'b1;
						rx_data <= sh_r[9:2];
						rx_err <= ~line_in;
					end
				end
				default: st_r <= UART_IDLE;
			endcase
		end
	end
endmodule : mdh_uart

//--- sim/mdh_checker.sv
// pin-level assertions between the driver end and the host end
`timescale 1ns/1ps
module mdh_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// shared arm pin
	input wire logic arm_host_o,
	input wire logic arm_host_oe,
	input wire logic arm_dev_o,
	input wire logic arm_dev_oe,
	// phase select and zero-cross pull
	input wire logic phase_select_lo,
	input wire logic phase_select_hi,
	input wire logic zc_oe,
	// status link pulls
	input wire logic link_dev_oe,
	input wire logic link_host_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// helper terms and sequences
	// ------------------------------------------------------------
	// host drives the arm pin high only during its pulse
	wire host_hi = arm_host_oe & arm_host_o;
	sequence arm_pulse_s;
		host_hi [*4] ##1 !arm_host_oe;
	endsequence
	// one bit time of 16 cycles, the edge cycle plus fifteen
	sequence bit_hold_s(sig);
		$stable(sig) [*8] ##1 $stable(sig) [*7];
	endsequence
	sequence start_s(sig);
		sig [*8] ##1 sig [*8];
	endsequence

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	arm_pulse_a: assert property ($rose(arm_host_oe) |-> arm_pulse_s)
		else $error("arm pulse has the wrong length");
	arm_latch_a: assert property ($rose(arm_dev_o) |-> $past(host_hi, 2) || $past(host_hi, 3))
		else $error("arm latched without a host pulse");
	arm_drive_a: assert property ($rose(arm_dev_o) |-> arm_dev_oe)
		else $error("arm latched but pin not driven");
	// code zero selects no winding, so the comparator output must freeze
	zc_hold_a: assert property ((!phase_select_lo && !phase_select_hi) [*4] |-> $stable(zc_oe))
		else $error("zero-cross moved with no phase selected");
	host_bit_a: assert property ($changed(link_host_oe) |=> bit_hold_s(link_host_oe))
		else $error("host link bit shorter than a bit time");
	dev_bit_a: assert property ($changed(link_dev_oe) |=> bit_hold_s(link_dev_oe))
		else $error("device link bit shorter than a bit time");
	host_start_a: assert property ($rose(link_host_oe) |-> start_s(link_host_oe))
		else $error("host low pull shorter than a bit");
	dev_start_a: assert property ($rose(link_dev_oe) |-> start_s(link_dev_oe))
		else $error("device low pull shorter than a bit");
endmodule : mdh_checker

//--- sim/test_motor_driver_host_signals.sv
// self-checking bench: driver end and host end joined at the pins
`timescale 1ns/1ps
module test_motor_driver_host_signals
	import mdh_pkg::*;
;
	// ------------------------------------------------------------
	// nets, counters, expected status bytes
	// ------------------------------------------------------------
	logic clock, rst, lin_other, amp1_above_dac, lin_fault_cond, dev_fault_cond, buck_fb_present;
	logic [2:0] phase_gt_sim, phase_gt_ext;
	logic lin_tx_data, arm_req, commute, ce_in, cmd_valid, held;
	logic [1:0] phase_code;
	logic [7:0] cmd_data, stat_data;
	logic lin_bus_oe, gate_enable, amp_enable, buck_enable, ldo5_enable, standby, hw_fault;
	logic buck_uvlo_fault, lin_rx_data, lin_fault_n, zero_cross, ovc_fault_n, cmd_ready;
	logic stat_valid, stat_err;
	logic [9:0] fr;
	logic [31:0] seed;
	int mismatches;
	int tests_run;
	int i;
	logic [7:0] notes[$];
	// lin bus wire is pulled up; either node pulls it dominant
	wire lin_bus = ~(lin_bus_oe | lin_other);
	mdh_if u_mdh_if ();
	mdh_device #(.STANDBY_CYC_P(20), .BUCK_SETTLE_P(10), .LINK_BIT_P(16)) u_mdh_device (
		.clock, .rst, .bus(u_mdh_if.dev), .lin_bus_in(lin_bus), .lin_bus_oe, .phase_gt_sim,
		.phase_gt_ext, .amp1_above_dac, .lin_fault_cond, .dev_fault_cond, .buck_fb_present,
		.gate_enable, .amp_enable, .buck_enable, .ldo5_enable, .standby, .hw_fault,
		.buck_uvlo_fault);
	mdh_host #(.ARM_CYC(4), .LINK_BIT_P(16)) u_mdh_host (
		.clock, .rst, .bus(u_mdh_if.host), .lin_tx_data, .lin_rx_data, .arm_req, .lin_fault_n,
		.commute, .phase_code, .ce_in, .zero_cross, .ovc_fault_n, .cmd_valid, .cmd_data,
		.cmd_ready, .stat_valid, .stat_data, .stat_err);
	mdh_checker u_mdh_checker (
		.clock, .rst, .arm_host_o(u_mdh_if.arm_host_o), .arm_host_oe(u_mdh_if.arm_host_oe),
		.arm_dev_o(u_mdh_if.arm_dev_o), .arm_dev_oe(u_mdh_if.arm_dev_oe),
		.phase_select_lo(u_mdh_if.phase_select_lo), .phase_select_hi(u_mdh_if.phase_select_hi),
		.zc_oe(u_mdh_if.zc_oe), .link_dev_oe(u_mdh_if.link_dev_oe),
		.link_host_oe(u_mdh_if.link_host_oe));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	// outputs are looked at on the falling edge, where they have settled
	task look(input int n);
		repeat (n) @(negedge clock);
	endtask : look
	// short enable dip: too brief to reach standby, long enough for an edge
	task ce_pulse();
		@(posedge clock) ce_in <= 1'b0;
		repeat (4) @(posedge clock);
		ce_in <= 1'b1;
	endtask : ce_pulse
	task arm();
		@(posedge clock) arm_req <= 1'b1;
		@(posedge clock) arm_req <= 1'b0;
	endtask : arm
	// a status frame takes 160 cycles; the bound of 1000 leaves room for six
	task drain();
		for (i = 0; i < 1000 && notes.size() != 0; i++) @(posedge clock);
		if (notes.size() != 0) begin
			mismatches++;
			$display("Error status queue expected empty seen %0d left", notes.size());
			finish_test();
		end
		look(4);
	endtask : drain
	task send(input logic [7:0] d);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_data <= d;
		for (i = 0; i < 400; i++) begin
			@(posedge clock);
			if (cmd_ready === 1'b1) break;
		end
		if (i == 400) begin
			mismatches++;
			$display("Error cmd_ready expected 1 seen %b", cmd_ready);
			finish_test();
		end
		cmd_valid <= 1'b0;
	endtask : send
	task zc_sweep(input logic use_ext);
		logic [2:0] s;
		for (int c = 1; c < 4; c++) begin
			@(posedge clock);
			commute <= 1'b1;
			phase_code <= 2'(c);
			@(posedge clock) commute <= 1'b0;
			for (int k = 0; k < 2; k++) begin
				seed = xs(seed);
				s = k ? ~s : seed[2:0];
				@(posedge clock);
				phase_gt_sim <= use_ext ? ~s : s;
				phase_gt_ext <= use_ext ? s : ~s;
				look(10);
				chk("zero_cross", s[c-1], zero_cross);
			end
			chk("phase_select", c, {u_mdh_if.phase_select_hi, u_mdh_if.phase_select_lo});
		end
		// no commute strobe: the select pins and the output both stay put
		@(posedge clock);
		commute <= 1'b1;
		phase_code <= PH_NONE;
		@(posedge clock) commute <= 1'b0;
		look(8);
		held = zero_cross;
		@(posedge clock);
		phase_code <= PH_C;
		phase_gt_sim <= ~phase_gt_sim;
		phase_gt_ext <= ~phase_gt_ext;
		look(10);
		chk("zc held", held, zero_cross);
		chk("phase_select", 0, {u_mdh_if.phase_select_hi, u_mdh_if.phase_select_lo});
	endtask : zc_sweep

	// ------------------------------------------------------------
	// watcher: each received status byte against the oldest note
	// ------------------------------------------------------------
	always @(posedge clock) begin
		if (stat_valid === 1'b1 && notes.size() != 0) begin
			chk("stat_data", notes.pop_front(), stat_data);
			chk("stat_err", 0, stat_err);
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		mismatches = 0;
		tests_run = 0;
		seed = 32'h3dc5;
		rst = 1'b1;
		{lin_other, amp1_above_dac, lin_fault_cond, dev_fault_cond, arm_req} = 5'h00;
		{commute, ce_in, cmd_valid, phase_gt_sim, phase_gt_ext} = 9'h000;
		{buck_fb_present, lin_tx_data, phase_code, cmd_data} = 12'hc00;
		notes.push_back(8'h01);
		notes.push_back(8'h05);
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		look(3);
		chk("buck before ldo5", 2'h2, {buck_enable, ldo5_enable});
		chk("link idle", 1, u_mdh_if.status_link_pin);
		drain();
		chk("amp_enable", 0, amp_enable);
		notes.push_back(8'h01);
		@(posedge clock) ce_in <= 1'b1;
		look(8);
		chk("amp_enable", 1, amp_enable);
		drain();
		notes.push_back(8'h05);
		notes.push_back(8'h01);
		@(posedge clock) ce_in <= 1'b0;
		look(12);
		chk("gates and standby", 2'h0, {gate_enable, standby});
		look(16);
		chk("standby", 1, standby);
		@(posedge clock) ce_in <= 1'b1;
		drain();
		notes.push_back(8'h11);
		@(posedge clock) amp1_above_dac <= 1'b1;
		look(10);
		chk("ovc_fault_n", 0, ovc_fault_n);
		drain();
		notes.push_back(8'h01);
		@(posedge clock) amp1_above_dac <= 1'b0;
		drain();
		chk("ovc_fault_n", 1, ovc_fault_n);
		notes.push_back(8'h81);
		@(posedge clock) dev_fault_cond <= 1'b1;
		ce_pulse();
		look(8);
		chk("fault kept while active", 3'h4, {hw_fault, ovc_fault_n, gate_enable});
		@(posedge clock) dev_fault_cond <= 1'b0;
		look(8);
		chk("fault latched", 2'h2, {hw_fault, ovc_fault_n});
		notes.push_back(8'h01);
		ce_pulse();
		look(12);
		chk("fault cleared", 2'h1, {hw_fault, ovc_fault_n});
		drain();
		@(posedge clock) lin_other <= 1'b1;
		look(8);
		chk("lin_rx_data", 0, lin_rx_data);
		@(posedge clock) lin_other <= 1'b0;
		notes.push_back(8'h09);
		arm();
		look(16);
		chk("armed pin", 2'h3, {lin_fault_n, u_mdh_if.lin_fault_tx_arm});
		@(posedge clock) lin_tx_data <= 1'b0;
		look(12);
		chk("lin dominant", 2'h2, {lin_bus_oe, lin_rx_data});
		@(posedge clock) lin_tx_data <= 1'b1;
		drain();
		notes.push_back(8'h29);
		notes.push_back(8'h21);
		@(posedge clock) lin_fault_cond <= 1'b1;
		drain();
		arm();
		look(16);
		chk("arm refused", 2'h0, {lin_fault_n, u_mdh_if.lin_fault_tx_arm});
		notes.push_back(8'h01);
		@(posedge clock) lin_fault_cond <= 1'b0;
		drain();
		zc_sweep(1'b0);
		notes.push_back(8'h03);
		fork
			send({seed[7:1], 1'b1});
			begin
				for (int j = 0; j < 50 && u_mdh_if.status_link_pin !== 1'b0; j++)
					@(negedge clock);
				look(8);
				for (int b = 0; b < 10; b++) begin
					fr[b] = u_mdh_if.status_link_pin;
					look(16);
				end
			end
		join
		chk("frame on pin", {1'b1, cmd_data, 1'b0}, fr);
		drain();
		zc_sweep(1'b1);
		// status bytes from here on are not predicted; the levels are
		@(posedge clock) buck_fb_present <= 1'b0;
		look(12);
		chk("buck fault", 3'h4, {buck_uvlo_fault, ovc_fault_n, ldo5_enable});
		ce_pulse();
		look(6);
		chk("retry", 2'h2, {buck_enable, ldo5_enable});
		look(20);
		chk("buck fault again", 1, buck_uvlo_fault);
		@(posedge clock) buck_fb_present <= 1'b1;
		ce_pulse();
		look(24);
		chk("buck recovered", 2'h1, {buck_uvlo_fault, ldo5_enable});
		finish_test();
	end
endmodule : test_motor_driver_host_signals
